// file: logic/fram_cmd_consts.svh
// Constants for the serial memory command interpreter
`ifndef FRAM_CMD_CONSTS_SVH
`define FRAM_CMD_CONSTS_SVH

// ==========================================================
// Opcodes
`define OP_RD_ANY_REG 8'h65
`define OP_WRITE 8'h02
`define OP_DDR_WRITE 8'hde
`define OP_FAST_WRITE 8'hda
`define OP_DDR_FAST_WRITE 8'hdd
`define OP_TWO_LANE_DATA 8'ha2
`define OP_TWO_LANE_ADDR_DATA 8'ha1
`define OP_FOUR_LANE_DATA 8'h32
`define OP_FOUR_LANE_ADDR_DATA 8'hd2
`define OP_DDR_FOUR_LANE 8'hd1

// ==========================================================
// Protocol codes on proto_i
`define PROTO_SPI 2'h0
`define PROTO_DPI 2'h1
`define PROTO_QPI 2'h2

// ==========================================================
// Field widths and positions
`define CMD_BITS 5'h08
`define ADDR_BITS 5'h18
`define BYTE_BITS 5'h08
`define MEM_ADDR_W 19
`define BLK_MSB 18
`define BLK_LSB 16

// ==========================================================
// Dummy clocks per latency code
`define LAT_DUMMY0 4'h0
`define LAT_DUMMY1 4'h2
`define LAT_DUMMY2 4'h4
`define LAT_DUMMY3 4'h6

// ==========================================================
// Reset values
`define RST_SCK 1'b0
`define RST_CS_N 1'b1
`define RST_IO 4'h0

`endif

// file: logic/fram_cmd_pkg.sv
// Types for the serial memory command interpreter
package fram_cmd_pkg;

  // ========================================================
  // Command phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CMD,
    PH_ADDR,
    PH_MODE,
    PH_DATA,
    PH_DUMMY,
    PH_DOUT,
    PH_SKIP
  } phase_t;

  typedef logic [2:0] lanes_t;

endpackage

// file: logic/fram_cmd_core.sv
// Command interpreter: register read and memory write commands
`timescale 1ns/100ps
`include "fram_cmd_consts.svh"

module fram_cmd_core
  import fram_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Configuration and status
  input wire logic [1:0] proto_i,
  input wire logic ddr_i,
  input wire logic latency_code_bit0_i,
  input wire logic latency_code_bit1_i,
  input wire logic write_enable_latch_i,
  input wire logic [7:0] prot_blk_i,
  // Register file access
  output logic [7:0] reg_sel_o,
  input wire logic [7:0] reg_data_i,
  // Memory array port
  output logic mem_we_o,
  output logic [18:0] mem_addr_o,
  output logic [7:0] mem_wdata_o
);

  // ========================================================
  // Functions
  function automatic lanes_t proto_lanes(input logic [1:0] p);
    case (p)
      `PROTO_DPI: proto_lanes = 3'h2;
      `PROTO_QPI: proto_lanes = 3'h4;
      default: proto_lanes = 3'h1;
    endcase
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io, input lanes_t n);
    case (n)
      3'h2: shift_in = {sh[21:0], io[1:0]};
      3'h4: shift_in = {sh[19:0], io[3:0]};
      default: shift_in = {sh[22:0], io[0]};
    endcase
  endfunction

  function automatic logic [3:0] dummy_of(input logic [1:0] code);
    case (code)
      2'h1: dummy_of = `LAT_DUMMY1;
      2'h2: dummy_of = `LAT_DUMMY2;
      2'h3: dummy_of = `LAT_DUMMY3;
      default: dummy_of = `LAT_DUMMY0;
    endcase
  endfunction

  // ========================================================
  // Pin synchronisers
  logic [2:0] sck_s_r;
  logic [2:0] cs_s_r;
  logic [3:0] io_s0_r;
  logic [3:0] io_s1_r;
  logic [3:0] io_s2_r;
  logic sck_q_r;
  logic cs_q_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_s_r <= {3{`RST_SCK}};
      cs_s_r <= {3{`RST_CS_N}};
      io_s0_r <= `RST_IO;
      io_s1_r <= `RST_IO;
      io_s2_r <= `RST_IO;
    end else begin
      sck_s_r <= {sck_s_r[1:0], sck_i};
      cs_s_r <= {cs_s_r[1:0], cs_n_i};
      io_s0_r <= io_i;
      io_s1_r <= io_s0_r;
      io_s2_r <= io_s1_r;
    end
  end

  logic sck_chg;
  logic cs_chg;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign sck_chg = (sck_s_r[1] == sck_s_r[2]) && (sck_s_r[2] != sck_q_r);
  assign cs_chg = (cs_s_r[1] == cs_s_r[2]) && (cs_s_r[2] != cs_q_r);
  assign sck_rise = sck_chg && sck_s_r[2];
  assign sck_fall = sck_chg && !sck_s_r[2];
  assign cs_fall = cs_chg && !cs_s_r[2];
  assign cs_rise = cs_chg && cs_s_r[2];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_q_r <= `RST_SCK;
      cs_q_r <= `RST_CS_N;
    end else begin
      if (sck_chg) begin
        sck_q_r <= sck_s_r[2];
      end
      if (cs_chg) begin
        cs_q_r <= cs_s_r[2];
      end
    end
  end

  // ========================================================
  // Command sequencer
  phase_t ph_r;
  logic [7:0] op_r;
  logic [23:0] sh_r;
  logic [4:0] cnt_r;
  lanes_t lanes_r;
  lanes_t dlanes_r;
  logic mode_r;
  logic ddr_r;
  logic [3:0] dum_r;
  logic [7:0] dout_r;
  logic first_r;
  logic [18:0] addr_r;

  logic active;
  logic samp;
  logic [23:0] nsh;
  logic [4:0] ncnt;
  logic [1:0] lat_code;

  assign active = !cs_q_r && !cs_rise;
  assign samp = active && (sck_rise || (ddr_r && sck_fall));
  assign nsh = shift_in(sh_r, io_s2_r, lanes_r);
  assign ncnt = cnt_r + {2'h0, lanes_r};
  assign lat_code = {latency_code_bit1_i, latency_code_bit0_i};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_r <= PH_IDLE;
      op_r <= 8'h00;
      sh_r <= 24'h000000;
      cnt_r <= 5'h00;
      lanes_r <= 3'h1;
      dlanes_r <= 3'h1;
      mode_r <= 1'b0;
      ddr_r <= 1'b0;
      dum_r <= 4'h0;
      addr_r <= 19'h00000;
      reg_sel_o <= 8'h00;
    end else if (cs_fall) begin
      ph_r <= PH_CMD;
      cnt_r <= 5'h00;
      ddr_r <= 1'b0;
      lanes_r <= proto_lanes(proto_i);
    end else if (!active) begin
      ph_r <= PH_IDLE;
      ddr_r <= 1'b0;
    end else begin
      case (ph_r)
        PH_CMD: begin
          if (samp) begin
            sh_r <= nsh;
            cnt_r <= ncnt;
            if (ncnt == `CMD_BITS) begin
              op_r <= nsh[7:0];
              cnt_r <= 5'h00;
              ph_r <= PH_ADDR;
              mode_r <= 1'b0;
              ddr_r <= 1'b0;
              lanes_r <= proto_lanes(proto_i);
              dlanes_r <= proto_lanes(proto_i);
              case (nsh[7:0])
                `OP_RD_ANY_REG: begin
                  ph_r <= PH_ADDR;
                end
                `OP_WRITE: begin
                  ph_r <= PH_ADDR;
                end
                `OP_FAST_WRITE: begin
                  mode_r <= 1'b1;
                end
                `OP_DDR_WRITE, `OP_DDR_FAST_WRITE: begin
                  if (proto_i == `PROTO_QPI && ddr_i) begin
                    ddr_r <= 1'b1;
                    mode_r <= (nsh[7:0] == `OP_DDR_FAST_WRITE);
                  end else begin
                    ph_r <= PH_SKIP;
                  end
                end
                `OP_TWO_LANE_DATA, `OP_TWO_LANE_ADDR_DATA,
                `OP_FOUR_LANE_DATA, `OP_FOUR_LANE_ADDR_DATA,
                `OP_DDR_FOUR_LANE: begin
                  if (proto_i == `PROTO_SPI) begin
                    mode_r <= 1'b1;
                    case (nsh[7:0])
                      `OP_TWO_LANE_DATA: begin
                        lanes_r <= 3'h1;
                        dlanes_r <= 3'h2;
                      end
                      `OP_TWO_LANE_ADDR_DATA: begin
                        lanes_r <= 3'h2;
                        dlanes_r <= 3'h2;
                      end
                      `OP_FOUR_LANE_DATA: begin
                        lanes_r <= 3'h1;
                        dlanes_r <= 3'h4;
                      end
                      default: begin
                        lanes_r <= 3'h4;
                        dlanes_r <= 3'h4;
                        ddr_r <= (nsh[7:0] == `OP_DDR_FOUR_LANE);
                      end
                    endcase
                  end else begin
                    ph_r <= PH_SKIP;
                  end
                end
                default: begin
                  ph_r <= PH_SKIP;
                end
              endcase
            end
          end
        end
        PH_ADDR: begin
          if (samp) begin
            sh_r <= nsh;
            cnt_r <= ncnt;
            if (ncnt == `ADDR_BITS) begin
              cnt_r <= 5'h00;
              addr_r <= nsh[`MEM_ADDR_W-1:0];
              lanes_r <= mode_r ? lanes_r : dlanes_r;
              if (op_r == `OP_RD_ANY_REG) begin
                reg_sel_o <= nsh[7:0];
                dum_r <= dummy_of(lat_code);
                ph_r <= (dummy_of(lat_code) == 4'h0) ? PH_DOUT : PH_DUMMY;
              end else begin
                ph_r <= mode_r ? PH_MODE : PH_DATA;
              end
            end
          end
        end
        PH_MODE: begin
          if (samp) begin
            cnt_r <= ncnt;
            if (ncnt == `BYTE_BITS) begin
              cnt_r <= 5'h00;
              lanes_r <= dlanes_r;
              ph_r <= PH_DATA;
            end
          end
        end
        PH_DATA: begin
          if (samp) begin
            sh_r <= nsh;
            cnt_r <= ncnt;
            if (ncnt == `BYTE_BITS) begin
              cnt_r <= 5'h00;
              addr_r <= addr_r + 19'h00001;
            end
          end
        end
        PH_DUMMY: begin
          if (active && sck_rise) begin
            dum_r <= dum_r - 4'h1;
            if (dum_r == 4'h1) begin
              ph_r <= PH_DOUT;
            end
          end
        end
        PH_DOUT: begin
          ph_r <= PH_DOUT;
        end
        PH_SKIP: begin
          ph_r <= PH_SKIP;
        end
        default: begin
          ph_r <= PH_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // Array write port
  logic byte_done;

  assign byte_done = (ph_r == PH_DATA) && active && samp && (ncnt == `BYTE_BITS);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_we_o <= 1'b0;
      mem_addr_o <= 19'h00000;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_we_o <= 1'b0;
      if (byte_done) begin
        mem_addr_o <= addr_r;
        mem_wdata_o <= nsh[7:0];
        mem_we_o <= write_enable_latch_i && !prot_blk_i[addr_r[`BLK_MSB:`BLK_LSB]];
      end
    end
  end

  // ========================================================
  // Register byte output
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_o <= `RST_IO;
      io_oe_o <= 4'h0;
      dout_r <= 8'h00;
      first_r <= 1'b0;
    end else if (!active || ph_r != PH_DOUT) begin
      io_o <= `RST_IO;
      io_oe_o <= 4'h0;
      first_r <= 1'b1;
    end else if (sck_fall) begin
      first_r <= 1'b0;
      case (lanes_r)
        3'h2: begin
          io_oe_o <= 4'h3;
          io_o <= {2'h0, (first_r ? reg_data_i[7:6] : dout_r[7:6])};
          dout_r <= first_r ? {reg_data_i[5:0], 2'h0} : {dout_r[5:0], 2'h0};
        end
        3'h4: begin
          io_oe_o <= 4'hf;
          io_o <= first_r ? reg_data_i[7:4] : dout_r[7:4];
          dout_r <= first_r ? {reg_data_i[3:0], 4'h0} : {dout_r[3:0], 4'h0};
        end
        default: begin
          io_oe_o <= 4'h2;
          io_o <= {2'h0, (first_r ? reg_data_i[7] : dout_r[7]), 1'b0};
          dout_r <= first_r ? {reg_data_i[6:0], 1'b0} : {dout_r[6:0], 1'b0};
        end
      endcase
    end
  end

endmodule // fram_cmd_core

// file: verification/fram_cmd_core_props.sv
// Concurrent checks on the command interpreter ports
`timescale 1ns/100ps
`include "fram_cmd_consts.svh"

module fram_cmd_core_props
  import fram_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pins and configuration
  input wire logic cs_n_i,
  input wire logic [1:0] proto_i,
  input wire logic write_enable_latch_i,
  input wire logic [7:0] prot_blk_i,
  input wire logic [3:0] io_oe_o,
  // Memory port
  input wire logic mem_we_o,
  input wire logic [18:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o
);
  // ========================================================
  // Last stored address within a frame
  logic [18:0] prev_addr_r;
  logic seen_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_addr_r <= 19'h00000;
      seen_r <= 1'b0;
    end else if (mem_we_o) begin
      prev_addr_r <= mem_addr_o;
      seen_r <= 1'b1;
    end else if (cs_n_i) begin
      seen_r <= 1'b0;
    end
  end

  // ========================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_commit;
    mem_we_o;
  endsequence
  sequence s_quiet;
    !mem_we_o [*6];
  endsequence
  property p_we_gap;
    s_commit |=> s_quiet;
  endproperty
  property p_oe_spi;
    (io_oe_o != 4'h0) && (proto_i == `PROTO_SPI) |-> io_oe_o == 4'h2;
  endproperty
  property p_oe_release;
    $rose(cs_n_i) |-> ##[1:6] (io_oe_o == 4'h0);
  endproperty
  property p_idle;
    cs_n_i [*8] |-> !mem_we_o;
  endproperty
  property p_latch;
    mem_we_o |-> write_enable_latch_i;
  endproperty
  property p_prot;
    mem_we_o |-> !prot_blk_i[mem_addr_o[18:16]];
  endproperty
  property p_addr_next;
    mem_we_o && seen_r |-> mem_addr_o == prev_addr_r + 19'h00001;
  endproperty
  property p_hold;
    mem_we_o |=> $stable(mem_addr_o) && $stable(mem_wdata_o);
  endproperty
  a_we_gap: assert property (p_we_gap) else $error("store pulses too close");
  a_oe_spi: assert property (p_oe_spi) else $error("wrong read lane enable");
  a_oe_release: assert property (p_oe_release) else $error("lane kept driven");
  a_idle: assert property (p_idle) else $error("store while deselected");
  a_latch: assert property (p_latch) else $error("store with latch clear");
  a_prot: assert property (p_prot) else $error("store into protected block");
  a_addr_next: assert property (p_addr_next) else $error("address not incremented");
  a_hold: assert property (p_hold) else $error("store fields moved");
endmodule // fram_cmd_core_props

bind fram_cmd_core fram_cmd_core_props u_props (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .cs_n_i(cs_n_i),
  .proto_i(proto_i),
  .write_enable_latch_i(write_enable_latch_i),
  .prot_blk_i(prot_blk_i),
  .io_oe_o(io_oe_o),
  .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o)
);

// file: verification/spi_host_model.sv
// Host serial bus controller model
`timescale 1ns/100ps

module spi_host_model (
  // Clock
  input wire logic clk_i,
  // Bus lines
  output logic cs_n_o = 1'b1,
  output logic sck_o = 1'b0,
  output logic [3:0] io_o = 4'h0,
  input wire logic [3:0] io_i
);
  // ========================================================
  // Frame control
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic start();
    cs_n_o <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    cs_n_o <= 1'b1;
    tick(8);
  endtask

  // ========================================================
  // Shift bits out MSB first, top lane carries the high bit
  task automatic shift(input logic [31:0] v, input int nbits, input int lanes);
    logic [31:0] s;
    s = v << (32 - nbits);
    for (int i = 0; i < nbits / lanes; i++) begin
      for (int k = 0; k < 4; k++) begin
        io_o[k] <= (k < lanes) ? s[32 - lanes + k] : ~io_o[k];
      end
      s = s << lanes;
      sck_o <= 1'b1;
      tick(4);
      sck_o <= 1'b0;
      tick(4);
    end
  endtask

  // ========================================================
  // Read one byte from lane one after rising edges
  task automatic read8(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      sck_o <= 1'b1;
      tick(4);
      d = {d[6:0], io_i[1]};
      sck_o <= 1'b0;
      tick(4);
    end
  endtask
endmodule // spi_host_model

// file: verification/serial_fram_reg_read_mem_write_tb.sv
// Self-checking bench for the command interpreter
`timescale 1ns/100ps

module serial_fram_reg_read_mem_write_tb;
  import fram_cmd_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cs_n, sck, ddr = 1'b0, lc0 = 1'b0, lc1 = 1'b0, write_enable_latch = 1'b1, mem_we;
  logic [1:0] proto = 2'h0;
  logic [3:0] host_io, io_w, io_dout, io_oe;
  logic [7:0] prot = 8'h00, reg_sel, reg_data, mem_wdata, rd;
  logic [18:0] mem_addr;
  logic [18:0] wa[$];
  logic [7:0] wd[$];
  int fails = 0;
  int check_count = 0;

  always #20 clk_i = ~clk_i;
  assign io_w = (io_oe & io_dout) | (~io_oe & host_io);
  assign reg_data = reg_sel ^ 8'h5a;
  always @(posedge clk_i) if (mem_we === 1'b1) begin
    wa.push_back(mem_addr);
    wd.push_back(mem_wdata);
  end

  spi_host_model h (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .io_o(host_io), .io_i(io_w));
  fram_cmd_core uut (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sck_i(sck), .io_i(io_w),
    .io_o(io_dout), .io_oe_o(io_oe), .proto_i(proto), .ddr_i(ddr), .latency_code_bit0_i(lc0),
    .latency_code_bit1_i(lc1), .write_enable_latch_i(write_enable_latch), .prot_blk_i(prot), .reg_sel_o(reg_sel),
    .reg_data_i(reg_data), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata));

  // ========================================================
  // Helpers
  task automatic give_verdict();
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] op, input int ol, input logic [23:0] a, input int al, input int dl,
                    input bit md, input logic [31:0] d, input int nb, input int extra);
    wa.delete();
    wd.delete();
    h.start();
    h.shift(op, 8, ol);
    h.shift(a, 24, al);
    if (md) h.shift(32'h0, 8, al);
    h.shift(d, 8 * nb, dl);
    h.shift(32'hf, extra, dl);
    h.stop();
  endtask
  task automatic expw(input int n, input logic [18:0] a0, input logic [31:0] d, input int nb, input int k0);
    logic [18:0] a;
    chk(wa.size(), n);
    for (int i = 0; i < n && i < wa.size(); i++) begin
      a = a0 + i[18:0];
      chk(wa[i], a);
      chk(wd[i], d[8 * (nb - 1 - k0 - i) +: 8]);
    end
  endtask

  // ========================================================
  // Opcode table: opcode, protocol, lanes for opcode, address, data, mode byte
  logic [7:0] ops[8] = '{8'h02, 8'hda, 8'ha2, 8'ha1, 8'h32, 8'hd2, 8'h02, 8'h02};
  logic [1:0] pr[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  int ol[8] = '{1, 1, 1, 1, 1, 1, 2, 4};
  int al[8] = '{1, 1, 1, 2, 1, 4, 2, 4};
  int dl[8] = '{1, 1, 2, 2, 4, 4, 2, 4};
  bit md[8] = '{0, 1, 1, 1, 1, 1, 0, 0};

  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wr(8'h02, 1, 24'hf7fffe, 1, 1, 0, 32'ha1b2c3, 3, 4);
    expw(3, 19'h7fffe, 32'ha1b2c3, 3, 0);
    write_enable_latch <= 1'b0;
    wr(8'h02, 1, 24'h000100, 1, 1, 0, 32'h55, 1, 0);
    expw(0, 19'h0, 32'h0, 1, 0);
    write_enable_latch <= 1'b1;
    prot <= 8'h80;
    wr(8'hda, 1, 24'h07ffff, 1, 1, 1, 32'h6677, 2, 0);
    expw(1, 19'h00000, 32'h6677, 2, 1);
    prot <= 8'h00;
    for (int i = 0; i < 8; i++) begin
      proto <= pr[i];
      wr(ops[i], ol[i], 24'h001000 * i, al[i], dl[i], md[i], 32'h3c00 | i, 2, 0);
      expw(2, 19'h01000 * i, 32'h3c00 | i, 2, 0);
    end
    proto <= 2'h0;
    wr(8'hde, 1, 24'h000200, 1, 1, 0, 32'h99, 1, 0);
    expw(0, 19'h0, 32'h0, 1, 0);
    for (int c = 0; c < 4; c++) begin
      {lc1, lc0} <= c[1:0];
      h.start();
      h.shift(32'h65, 8, 1);
      h.shift(c[0] ? 32'h070006 : 32'h000006, 24, 1);
      h.shift(32'h0, 2 * c, 1);
      h.read8(rd);
      h.stop();
      chk(rd, 8'h5c);
    end
    give_verdict();
  end

  initial begin
    #2ms;
    fails++;
    give_verdict();
  end
endmodule // serial_fram_reg_read_mem_write_tb
